// *** hw/ccde_consts.svh ***
`ifndef CCDE_CONSTS_SVH
`define CCDE_CONSTS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define CCDE_OP_CLRACC 14'h0103
`define CCDE_OP_WDRST 14'h0064
`define CCDE_OP_COMP 6'h09
`define CCDE_OP_DEC 6'h03
`define CCDE_OP_HI_MSB 13
`define CCDE_OP_HI_LSB 8
`define CCDE_DEST_BIT 7
`define CCDE_ADDR_MSB 6

// ----------------------------------------
// register map (word byte addresses)
// ----------------------------------------
`define CCDE_REG_INSN 4'h0
`define CCDE_REG_ACC 4'h4
`define CCDE_REG_STAT 4'h8
`define CCDE_REG_FADDR 4'hc

// ----------------------------------------
// status register fields and resets
// ----------------------------------------
`define CCDE_ST_ZERO 0
`define CCDE_ST_EXPIRY 1
`define CCDE_ST_SLEEP 2
`define CCDE_ZERO_BYTE 8'h00
`define CCDE_ONE_BYTE 8'h01
`define CCDE_WDT_W 8
`define CCDE_PRE_W 8

`endif

// *** hw/ccde_pkg.sv ***
package ccde_pkg;
	typedef struct packed {
		logic [13:0] word;
		logic valid;
	} ccde_insn_t;

	typedef enum logic [2:0] {
		CCDE_NONE,
		CCDE_CLRACC,
		CCDE_WDRST,
		CCDE_COMP,
		CCDE_DEC
	} ccde_op_t;

	typedef struct packed {
		ccde_op_t op;
		logic to_file;
		logic [6:0] addr;
	} ccde_dec_t;

	typedef struct packed {
		logic acc_we;
		logic file_we;
		logic zero_we;
		logic zero_val;
		logic wdt_clr;
		logic [7:0] value;
	} ccde_res_t;
endpackage

// *** hw/ccde_decode.sv ***
`timescale 1ns/1ps
`include "ccde_consts.svh"
module ccde_decode (
	// instruction in
	input wire ccde_pkg::ccde_insn_t insn_i,
	// decoded out
	output ccde_pkg::ccde_dec_t dec_o
);
	logic [5:0] hi;
	assign hi = insn_i.word[`CCDE_OP_HI_MSB:`CCDE_OP_HI_LSB];

	always_comb begin
		dec_o.to_file = insn_i.word[`CCDE_DEST_BIT];
		dec_o.addr = insn_i.word[`CCDE_ADDR_MSB:0];
		dec_o.op = ccde_pkg::CCDE_NONE;
		if (insn_i.valid) begin
			if (insn_i.word == `CCDE_OP_CLRACC) begin
				dec_o.op = ccde_pkg::CCDE_CLRACC;
			end else if (insn_i.word == `CCDE_OP_WDRST) begin
				dec_o.op = ccde_pkg::CCDE_WDRST;
			end else if (hi == `CCDE_OP_COMP) begin
				dec_o.op = ccde_pkg::CCDE_COMP;
			end else if (hi == `CCDE_OP_DEC) begin
				dec_o.op = ccde_pkg::CCDE_DEC;
			end
		end
	end
endmodule

// *** hw/ccde_alu.sv ***
`timescale 1ns/1ps
`include "ccde_consts.svh"
module ccde_alu (
	// decoded op and operand
	input wire ccde_pkg::ccde_dec_t dec_i,
	input wire logic [7:0] operand_i,
	// result
	output ccde_pkg::ccde_res_t res_o
);
	logic [7:0] val;

	always_comb begin
		val = `CCDE_ZERO_BYTE;
		res_o.acc_we = 1'b0;
		res_o.file_we = 1'b0;
		res_o.zero_we = 1'b0;
		res_o.wdt_clr = 1'b0;
		unique case (dec_i.op)
			ccde_pkg::CCDE_NONE: begin
			end
			ccde_pkg::CCDE_CLRACC: begin
				res_o.acc_we = 1'b1;
				res_o.zero_we = 1'b1;
			end
			ccde_pkg::CCDE_WDRST: begin
				res_o.wdt_clr = 1'b1;
			end
			ccde_pkg::CCDE_COMP: begin
				val = ~operand_i;
				res_o.zero_we = 1'b1;
				res_o.acc_we = ~dec_i.to_file;
				res_o.file_we = dec_i.to_file;
			end
			ccde_pkg::CCDE_DEC: begin
				val = operand_i - `CCDE_ONE_BYTE;
				res_o.zero_we = 1'b1;
				res_o.acc_we = ~dec_i.to_file;
				res_o.file_we = dec_i.to_file;
			end
			default: begin
			end
		endcase
		res_o.value = val;
		res_o.zero_val = (val == `CCDE_ZERO_BYTE);
	end
endmodule

// *** hw/ccde_exec.sv ***
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ccde_consts.svh"
module ccde_exec #(
	parameter int WDT_W = `CCDE_WDT_W,
	parameter int PRE_W = `CCDE_PRE_W
) (
	// clock, reset, enable
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// file register port
	output logic [6:0] file_addr_o,
	input wire logic [7:0] file_rdata_i,
	output logic file_we_o,
	output logic [7:0] file_wdata_o,
	// watchdog and state
	output logic [WDT_W-1:0] wdt_count_o,
	output logic [PRE_W-1:0] wdt_presc_o,
	output logic [7:0] acc_o,
	output logic zero_o,
	output logic expiry_status_bit_o,
	output logic sleep_status_bit_o
);
	// ----------------------------------------
	// bus access
	// ----------------------------------------
	logic acc_req;
	logic wr_req;
	logic ack_r;
	logic [31:0] rdat_r;
	ccde_pkg::ccde_insn_t insn;
	ccde_pkg::ccde_dec_t dec;
	ccde_pkg::ccde_res_t res;
	logic [7:0] acc_r;
	logic zero_r;
	logic expiry_r;
	logic sleep_r;
	logic [WDT_W-1:0] wdt_r;
	logic [PRE_W-1:0] pre_r;
	logic [7:0] faddr_r;
	logic file_we_r;
	logic [7:0] file_wdata_r;

	assign acc_req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr_req = acc_req & wb_we_i;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;

	// a write to the instruction register executes it in that cycle
	assign insn.word = wb_dat_i[13:0];
	assign insn.valid = ce_i & wr_req & (wb_adr_i == `CCDE_REG_INSN)
		& wb_sel_i[0] & wb_sel_i[1];

	ccde_decode u_dec (
		.insn_i(insn),
		.dec_o(dec)
	);

	// file register read is combinational so execution is one cycle
	assign file_addr_o = dec.addr;

	ccde_alu u_alu (
		.dec_i(dec),
		.operand_i(file_rdata_i),
		.res_o(res)
	);

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			ack_r <= 1'b0;
		end else if (ce_i) begin
			ack_r <= acc_req;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (ce_i && acc_req && !wb_we_i) begin
			unique case (wb_adr_i)
				`CCDE_REG_ACC: rdat_r <= {24'h00_0000, acc_r};
				`CCDE_REG_STAT: rdat_r <= {29'h0000_0000, sleep_r,
					expiry_r, zero_r};
				`CCDE_REG_FADDR: rdat_r <= {24'h00_0000, faddr_r};
				default: rdat_r <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// architectural state
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			acc_r <= `CCDE_ZERO_BYTE;
		end else if (ce_i && res.acc_we) begin
			acc_r <= res.value;
		end else if (ce_i && wr_req && wb_adr_i == `CCDE_REG_ACC
			&& wb_sel_i[0]) begin
			acc_r <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			zero_r <= 1'b0;
		end else if (ce_i && res.zero_we) begin
			zero_r <= res.zero_val;
		end
	end

	// status bits read as one after restart; reset leaves them set too
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			expiry_r <= 1'b1;
			sleep_r <= 1'b1;
		end else if (ce_i && res.wdt_clr) begin
			expiry_r <= 1'b1;
			sleep_r <= 1'b1;
		end else if (ce_i && wr_req && wb_adr_i == `CCDE_REG_STAT
			&& wb_sel_i[0]) begin
			expiry_r <= wb_dat_i[`CCDE_ST_EXPIRY];
			sleep_r <= wb_dat_i[`CCDE_ST_SLEEP];
		end
	end

	// watchdog counts while enabled and wraps at full count; only restart and reset clear it early
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			wdt_r <= '0;
			pre_r <= '0;
		end else if (ce_i && res.wdt_clr) begin
			wdt_r <= '0;
			pre_r <= '0;
		end else if (ce_i) begin
			pre_r <= pre_r + 1'b1;
			if (&pre_r) begin
				wdt_r <= wdt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			faddr_r <= `CCDE_ZERO_BYTE;
			file_we_r <= 1'b0;
			file_wdata_r <= `CCDE_ZERO_BYTE;
		end else if (ce_i) begin
			file_we_r <= res.file_we;
			if (res.file_we) begin
				faddr_r <= {1'b0, dec.addr};
				file_wdata_r <= res.value;
			end
		end
	end

	assign file_we_o = file_we_r;
	assign file_wdata_o = file_wdata_r;
	assign wdt_count_o = wdt_r;
	assign wdt_presc_o = pre_r;
	assign acc_o = acc_r;
	assign zero_o = zero_r;
	assign expiry_status_bit_o = expiry_r;
	assign sleep_status_bit_o = sleep_r;
endmodule

// *** testbench/ccde_exec_checker.sv ***
`timescale 1ns/1ps
module ccde_exec_checker #(
	parameter int WDT_W = 8,
	parameter int PRE_W = 8
) (
	// clock and bus
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	// core state
	input wire logic [7:0] file_rdata_i,
	input wire logic file_we_o,
	input wire logic [7:0] file_wdata_o,
	input wire logic [WDT_W-1:0] wdt_count_o,
	input wire logic [PRE_W-1:0] wdt_presc_o,
	input wire logic [7:0] acc_o,
	input wire logic zero_o,
	input wire logic expiry_status_bit_o,
	input wire logic sleep_status_bit_o
);
	logic iw;
	logic cd;
	logic [13:0] op;
	logic [7:0] res;
	// sel is not watched: a narrow instruction write would raise iw though the core, which needs sel bits 0 and 1, does not execute it
	assign op = wb_dat_i[13:0];
	assign iw = wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && wb_we_i
		&& wb_adr_i == 4'h0;
	assign cd = iw && (op[13:8] == 6'h09 || op[13:8] == 6'h03);
	assign res = op[13:8] == 6'h09 ? ~file_rdata_i : file_rdata_i - 8'h01;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	chk_clear_acc: assert property (iw && op == 14'h0103 |=>
		acc_o == 8'h00 && zero_o) else $error("clear left acc or zero");
	chk_one_cycle: assert property (iw |=> wb_ack_o ##1 !wb_ack_o)
		else $error("instruction not done in one cycle");
	chk_wdt_restart: assert property (iw && op == 14'h0064 |=>
		wdt_count_o == '0 && wdt_presc_o == '0) else $error("wdt not cleared");
	chk_status_set: assert property (iw && op == 14'h0064 |=>
		expiry_status_bit_o && sleep_status_bit_o) else $error("status not set");
	chk_acc_target: assert property (cd && !op[7] |=>
		acc_o == $past(res) && !file_we_o) else $error("bad acc result");
	chk_file_target: assert property (cd && op[7] |=>
		file_we_o && file_wdata_o == $past(res) && $stable(acc_o))
		else $error("bad file result");
	chk_zero_flag: assert property (cd |=>
		zero_o == ($past(res) == 8'h00)) else $error("bad zero flag");
	chk_we_pulse: assert property (file_we_o |=> !file_we_o)
		else $error("file write longer than one cycle");
endmodule

bind ccde_exec ccde_exec_checker #(.WDT_W(WDT_W), .PRE_W(PRE_W)) u_chk (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.file_rdata_i(file_rdata_i), .file_we_o(file_we_o),
	.file_wdata_o(file_wdata_o), .wdt_count_o(wdt_count_o),
	.wdt_presc_o(wdt_presc_o), .acc_o(acc_o), .zero_o(zero_o),
	.expiry_status_bit_o(expiry_status_bit_o),
	.sleep_status_bit_o(sleep_status_bit_o));

// *** testbench/tb_ccde_exec.sv ***
`timescale 1ns/1ps
module tb_ccde_exec;
	logic core_clk_i, nrst_i, cyc, stb, we, ack, we_f, fwe, zero, ex_b, sl_b;
	logic ce;
	logic [6:0] fa;
	logic [3:0] adr;
	logic [31:0] dat, q, rdat;
	logic [7:0] fin, wd, fwd, acc, r, ea, wdt, pre;
	logic [13:0] ov [5] = '{14'h0900, 14'h09ff, 14'h03d5, 14'h037f, 14'h03aa};
	logic [7:0] fv [5] = '{8'h13, 8'hff, 8'h01, 8'h00, 8'h10};
	int fails, check_count;
	ccde_exec DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.file_addr_o(fa), .file_rdata_i(fin), .file_we_o(we_f),
		.file_wdata_o(wd), .wdt_count_o(wdt), .wdt_presc_o(pre),
		.acc_o(acc), .zero_o(zero), .expiry_status_bit_o(ex_b),
		.sleep_status_bit_o(sl_b));
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// the file write pulse shares the ack cycle, so it is caught there
	// the leading edge keeps the bus idle for a cycle between two calls;
	// outputs are read at the edge before that edge's updates land
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			fails++;
			final_report;
		end
		fwe = we_f;
		fwd = wd;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task ex(input logic [13:0] o);
		wb(1'b1, 4'h0, {18'h0, o});
	endtask
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	initial begin
		nrst_i = 1'b0;
		ce = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		dat = 32'h0;
		fin = 8'h00;
		fails = 0;
		check_count = 0;
		repeat (10) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		wb(1'b0, 4'h8, 32'h0);
		chk(q, 32'h6);
		wb(1'b0, 4'h2, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, 4'h4, 32'h5a);
		ex(14'h0103);
		chk(32'(acc), 32'h0);
		wb(1'b1, 4'h8, 32'h0);
		wb(1'b0, 4'h8, 32'h0);
		chk(q, 32'h1);
		// long enough for the counter to leave zero
		repeat (600) @(posedge core_clk_i);
		chk(32'(wdt != 8'h00), 32'h1);
		ex(14'h0064);
		chk(32'(wdt), 32'h0);
		chk(32'(pre), 32'h0);
		chk(32'({sl_b, ex_b}), 32'h3);
		// a low enable must hold the prescaler where it stands
		ce <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		chk(32'(pre), 32'h1);
		ce <= 1'b1;
		wb(1'b0, 4'h8, 32'h0);
		chk(q, 32'h7);
		ea = 8'h00;
		for (int i = 0; i < 5; i++) begin
			fin <= fv[i];
			ex(ov[i]);
			chk(32'(fa), 32'(ov[i][6:0]));
			r = ov[i][11] ? ~fv[i] : fv[i] - 8'h01;
			chk(32'(fwe), 32'(ov[i][7]));
			if (ov[i][7]) begin
				chk(32'(fwd), 32'(r));
				wb(1'b0, 4'hc, 32'h0);
				chk(q, 32'(ov[i][6:0]));
			end else begin
				ea = r;
			end
			chk(32'(acc), 32'(ea));
			chk(32'(zero), 32'(r == 8'h00));
		end
		// a second reset in mid-run must bring the state back
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		wb(1'b0, 4'h8, 32'h0);
		chk(q, 32'h6);
		chk(32'(acc), 32'h0);
		final_report;
	end
endmodule
